// ### verilog/asrs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module asrs_sequencer #(
  parameter int CONV_CYCLES = asrs_pkg::CONV_CYCLES_DEFAULT,
  parameter int FIFO_DEPTH  = 8
) (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                sclk_i,
  input  wire logic                cs_n_i,
  input  wire logic                frame_sync_i,
  input  wire logic                conv_start_n_i,
  input  wire asrs_pkg::asrs_cfg_t config_word_i,
  input  wire asrs_pkg::asrs_frame_t frame_info_i,
  output logic                     conv_go_o,
  output logic                     converting_o,
  output logic                     result_push_o,
  output logic                     fifo_clear_o,
  output logic [3:0]               fifo_level_o,
  output logic                     eoc_o,
  output logic                     int_n_o
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic sclk_rise;
  logic cs_lvl, cs_rise, cs_fall;
  logic fs_rise;
  logic cst_lvl, cst_rise;

  asrs_edge_sync u_sclk (.clk_i(clk_i), .reset_i(reset_i), .async_i(sclk_i),
    .level_o(), .rise_o(sclk_rise), .fall_o());
  asrs_edge_sync u_cs (.clk_i(clk_i), .reset_i(reset_i), .async_i(cs_n_i),
    .level_o(cs_lvl), .rise_o(cs_rise), .fall_o(cs_fall));
  asrs_edge_sync u_fs (.clk_i(clk_i), .reset_i(reset_i), .async_i(frame_sync_i),
    .level_o(), .rise_o(fs_rise), .fall_o());
  asrs_edge_sync u_cst (.clk_i(clk_i), .reset_i(reset_i), .async_i(conv_start_n_i),
    .level_o(cst_lvl), .rise_o(cst_rise), .fall_o());

  // ****************************************************************
  // Frame edge counting and triggers
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_CONV} asrs_state_t;

  asrs_state_t                   state_q, state_d;
  logic [asrs_pkg::EDGE_CNT_W-1:0] edges_q, edges_d;
  logic                          in_frame_q, in_frame_d;
  logic [asrs_pkg::CNT_W-1:0]    conv_cnt_q, conv_cnt_d;
  logic [asrs_pkg::CNT_W-1:0]    low_cnt_q, low_cnt_d;
  logic [3:0]                    level_q, level_d;
  logic                          int_pend_q, int_pend_d;
  logic                          eoc_q, eoc_d;
  logic                          go_q, go_d;
  logic                          push_q, push_d;
  logic                          clr_q, clr_d;
  logic [asrs_pkg::EDGE_CNT_W-1:0] frame_edges;
  logic                          frame_start, frame_end, frame_trig, strobe_trig, trig;
  logic                          one_shot, repeat_md;

  assign one_shot    = config_word_i.mode == asrs_pkg::ASRS_MODE_ONE_SHOT;
  assign repeat_md   = config_word_i.mode == asrs_pkg::ASRS_MODE_REPEAT;
  assign frame_edges = config_word_i.long_sample
                       ? asrs_pkg::EDGE_CNT_W'(asrs_pkg::FRAME_EDGES_LONG)
                       : asrs_pkg::EDGE_CNT_W'(asrs_pkg::FRAME_EDGES_SHORT);
  // Frame sync may run with chip select held low, so either one opens a frame.
  assign frame_start = cs_fall | (fs_rise & ~cs_lvl);
  assign frame_end   = cs_rise;
  // Counting stops at the trigger edge so one frame can give only one conversion.
  assign frame_trig  = in_frame_q && !config_word_i.extended && sclk_rise
                       && (edges_q == frame_edges - asrs_pkg::EDGE_CNT_W'(1));
  // The strobe counts only while chip select is high and after a full low time.
  assign strobe_trig = config_word_i.extended && cs_lvl && cst_rise
                       && (low_cnt_q >= asrs_pkg::CNT_W'(asrs_pkg::CONV_START_LOW_CYC));
  assign trig        = (frame_trig || strobe_trig) && (one_shot || repeat_md);

  always_comb
  begin
    edges_d    = edges_q;
    in_frame_d = in_frame_q;
    low_cnt_d  = cst_lvl ? '0 : (low_cnt_q == '1 ? low_cnt_q : low_cnt_q + asrs_pkg::CNT_W'(1));
    if (frame_start)
    begin
      in_frame_d = 1'b1;
      edges_d    = '0;
    end
    else if (frame_end)
      in_frame_d = 1'b0;
    else if (in_frame_q && sclk_rise)
    begin
      edges_d = edges_q + asrs_pkg::EDGE_CNT_W'(1);
      if (frame_trig)
        in_frame_d = 1'b0;
    end
  end

  // ****************************************************************
  // Conversion, FIFO level and completion
  // ****************************************************************
  always_comb
  begin
    state_d    = state_q;
    conv_cnt_d = conv_cnt_q;
    level_d    = level_q;
    int_pend_d = int_pend_q;
    eoc_d      = eoc_q;
    go_d       = 1'b0;
    push_d     = 1'b0;
    clr_d      = 1'b0;
    // Servicing an interrupt: a readout pops one entry, anything else clears in repeat mode only.
    if (frame_start && int_pend_q && repeat_md && !frame_info_i.fifo_read)
    begin
      level_d = '0;
      clr_d   = 1'b1;
    end
    else if (frame_start && frame_info_i.fifo_read && level_q != '0)
      level_d = level_q - 4'h1;
    if (frame_start && int_pend_q && (one_shot || repeat_md))
      int_pend_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (trig)
        begin
          state_d    = ST_CONV;
          conv_cnt_d = '0;
          go_d       = 1'b1;
          eoc_d      = one_shot && config_word_i.pin_is_eoc;
        end
      end
      ST_CONV:
      begin
        conv_cnt_d = conv_cnt_q + asrs_pkg::CNT_W'(1);
        if (conv_cnt_q == asrs_pkg::CNT_W'(CONV_CYCLES - 1))
        begin
          state_d = ST_IDLE;
          eoc_d   = 1'b0;
          if (one_shot)
            int_pend_d = !config_word_i.pin_is_eoc;
          else
          begin
            push_d = 1'b1;
            if (level_d != 4'(FIFO_DEPTH))
              level_d = level_d + 4'h1;
            if (level_d == config_word_i.fifo_thresh)
              int_pend_d = 1'b1;
          end
        end
      end
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q    <= ST_IDLE;
      edges_q    <= '0;
      in_frame_q <= 1'b0;
      conv_cnt_q <= '0;
      low_cnt_q  <= '0;
      level_q    <= '0;
      int_pend_q <= 1'b0;
      eoc_q      <= 1'b0;
      go_q       <= 1'b0;
      push_q     <= 1'b0;
      clr_q      <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      edges_q    <= edges_d;
      in_frame_q <= in_frame_d;
      conv_cnt_q <= conv_cnt_d;
      low_cnt_q  <= low_cnt_d;
      level_q    <= level_d;
      int_pend_q <= int_pend_d;
      eoc_q      <= eoc_d;
      go_q       <= go_d;
      push_q     <= push_d;
      clr_q      <= clr_d;
    end
  end

  assign conv_go_o     = go_q;
  assign converting_o  = state_q == ST_CONV;
  assign result_push_o = push_q;
  assign fifo_clear_o  = clr_q;
  assign fifo_level_o  = level_q;
  // Outside mode 00 the pin is always an interrupt.
  assign eoc_o         = eoc_q && one_shot;
  assign int_n_o       = ~int_pend_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_GO_ONLY_IDLE: assert property (@(posedge clk_i) disable iff (reset_i)
    go_q |-> $past(state_q) == ST_IDLE && state_q == ST_CONV)
    else $error("Conversion started while busy.");
  AST_NO_GO_EXT_CS_LOW: assert property (@(posedge clk_i) disable iff (reset_i)
    (config_word_i.extended && $past(config_word_i.extended) && go_q) |-> $past(cs_lvl))
    else $error("Extended start while chip select low.");
  AST_STROBE_RISE: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(go_q) && config_word_i.extended && $past(config_word_i.extended) |-> $past(cst_rise))
    else $error("Extended start not on strobe rising edge.");
  AST_EOC_NOT_REPEAT: assert property (@(posedge clk_i) disable iff (reset_i)
    !one_shot |-> !eoc_o)
    else $error("End-of-conversion outside mode 00.");
  AST_CONV_LEN: assert property (@(posedge clk_i) disable iff (reset_i)
    go_q |-> converting_o [*2])
    else $error("Conversion ended too soon.");
  AST_CLEAR_EMPTY: assert property (@(posedge clk_i) disable iff (reset_i)
    clr_q |-> level_q == 4'h0)
    else $error("FIFO not empty after clear.");
  AST_PUSH_REPEAT: assert property (@(posedge clk_i) disable iff (reset_i)
    push_q |-> !$past(one_shot))
    else $error("Result pushed in mode 00.");
  AST_INT_AT_THRESH: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(int_pend_q) && repeat_md && $past(repeat_md) |-> level_q == config_word_i.fifo_thresh)
    else $error("Interrupt away from threshold.");

  COV_FRAME_CONV: cover property (@(posedge clk_i) disable iff (reset_i) frame_trig && state_q == ST_IDLE);
  COV_STROBE_CONV: cover property (@(posedge clk_i) disable iff (reset_i) strobe_trig && state_q == ST_IDLE);
  COV_INT_REPEAT: cover property (@(posedge clk_i) disable iff (reset_i) $rose(int_pend_q) && repeat_md);
  COV_CLEAR: cover property (@(posedge clk_i) disable iff (reset_i) clr_q);

endmodule

`default_nettype wire

// ### verilog/asrs_pkg.sv
package asrs_pkg;

  // ****************************************************************
  // Conversion modes and sampling
  // ****************************************************************
  typedef enum logic [1:0] {
    ASRS_MODE_ONE_SHOT     = 2'h0,
    ASRS_MODE_REPEAT       = 2'h1,
    ASRS_MODE_SWEEP        = 2'h2,
    ASRS_MODE_REPEAT_SWEEP = 2'h3
  } asrs_mode_t;

  localparam int FRAME_EDGES_SHORT = 16;
  localparam int FRAME_EDGES_LONG  = 28;
  localparam int EDGE_CNT_W        = 5;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ              = 25000000;
  localparam int CONV_START_LOW_NS   = 800;
  localparam int CONV_START_LOW_CYC  = (CONV_START_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CONV_CYCLES_DEFAULT = 35;
  localparam int FIFO_THRESH_DEFAULT = 4;
  localparam int CNT_W               = 8;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    asrs_mode_t mode;
    logic       extended;
    logic       long_sample;
    logic       pin_is_eoc;
    logic [3:0] fifo_thresh;
  } asrs_cfg_t;

  typedef struct packed {
    logic select;
    logic fifo_read;
    logic mode_write;
  } asrs_frame_t;

endpackage

// ### verilog/asrs_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Two-flop synchroniser with edge detection
// ****************************************************************
// The first flop feeds only the second; edges are found on the later stages.
module asrs_edge_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic last_q;
  logic last_d;

  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~last_q;
  assign fall_o  = ~sync_q & last_q;

endmodule

`default_nettype wire

// ### verif/asrs_host.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Host serial port model
// ****************************************************************
// The serial clock idles high and only runs inside frames.
module asrs_host (
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      frame_sync_o,
  output logic      conv_start_n_o
);
  initial
  begin
    sclk_o         = 1'b1;
    cs_n_o         = 1'b1;
    frame_sync_o   = 1'b0;
    conv_start_n_o = 1'b1;
  end

  // One frame selects, reads and, with enough edges, starts a conversion.
  task automatic frame(input int edges);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < edges; i++)
    begin
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    cs_n_o <= 1'b1;
  endtask

  // The strobe is held low for the given count of cycles, then released.
  task automatic strobe(input int low_cyc);
    @(posedge clk_i);
    conv_start_n_o <= 1'b0;
    repeat (low_cyc) @(posedge clk_i);
    conv_start_n_o <= 1'b1;
  endtask
endmodule

`default_nettype wire

// ### verif/test_asrs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module test_asrs_sequencer;
  localparam int CONV = 8;
  logic                  clk_i, reset_i, sclk, cs_n, fs, cst_n, go, busy, push, clr, eoc, int_n, eoc_q;
  logic [3:0]            lvl;
  asrs_pkg::asrs_cfg_t   cfg;
  asrs_pkg::asrs_frame_t fi;
  int                    n_mismatch, cmp_count, n_go, n_clr, n_eoc, n_push, t, k, g0, p0;

  asrs_host host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .frame_sync_o(fs), .conv_start_n_o(cst_n));
  asrs_sequencer #(.CONV_CYCLES(CONV), .FIFO_DEPTH(8)) DUT (.clk_i(clk_i), .reset_i(reset_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .frame_sync_i(fs), .conv_start_n_i(cst_n), .config_word_i(cfg),
    .frame_info_i(fi), .conv_go_o(go), .converting_o(busy), .result_push_o(push), .fifo_clear_o(clr),
    .fifo_level_o(lvl), .eoc_o(eoc), .int_n_o(int_n));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Pulses are counted as they land so scenarios only compare totals.
  always @(posedge clk_i)
  begin
    if (go === 1'b1) n_go++;
    if (clr === 1'b1) n_clr++;
    if (push === 1'b1) n_push++;
    if (eoc === 1'b1 && eoc_q !== 1'b1) n_eoc++;
    eoc_q = eoc;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait for the conversion to finish; a hang ends the run.
  task automatic settle();
    repeat (CONV + 8) @(posedge clk_i);
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk_i);
    if (busy !== 1'b0)
    begin
      n_mismatch++;
      $display("mismatch converting expected 0 seen %b", busy);
      end_of_test();
    end
  endtask

  task automatic frame(input int e, input logic rd);
    fi <= '{select: 1'b1, fifo_read: rd, mode_write: 1'b0};
    host.frame(e);
    settle();
  endtask

  task automatic setc(input logic [1:0] m, input logic x, input logic ln, input logic pe, input logic [3:0] th);
    @(posedge clk_i);
    cfg <= '{mode: asrs_pkg::asrs_mode_t'(m), extended: x, long_sample: ln, pin_is_eoc: pe, fifo_thresh: th};
  endtask

  initial
  begin
    reset_i = 1'b1;
    cfg     = '0;
    fi      = '0;
    eoc_q   = 1'b0;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    void'($urandom(32'h4dc794f0));
    k = 1 + ($urandom % 3);
    t = 1 + ($urandom % 4);
    // ****************************************************************
    // One-shot, normal sampling
    // ****************************************************************
    setc(2'h0, 1'b0, 1'b0, 1'b1, 4'h1);
    g0 = n_go;
    repeat (k) frame(16, 1'b0);
    chk("conv_go count", 4'(k), 4'(n_go - g0));
    chk("eoc pulses", 4'(k), 4'(n_eoc));
    setc(2'h0, 1'b0, 1'b1, 1'b0, 4'h1);
    frame(16, 1'b0);
    chk("short frame, long sampling", 4'(k), 4'(n_go - g0));
    frame(28, 1'b0);
    chk("long frame conv_go", 4'(k + 1), 4'(n_go - g0));
    chk("int_n after conversion", 4'h0, {3'h0, int_n});
    frame(4, 1'b1);
    chk("int_n after service", 4'h1, {3'h0, int_n});
    // ****************************************************************
    // One-shot, extended sampling
    // ****************************************************************
    setc(2'h0, 1'b1, 1'b0, 1'b1, 4'h1);
    g0 = n_go;
    frame(16, 1'b0);
    chk("frame ignored", 4'h0, 4'(n_go - g0));
    host.strobe(24);
    settle();
    chk("strobe conv_go", 4'h1, 4'(n_go - g0));
    fork
      frame(20, 1'b0);
      begin
        repeat (8) @(posedge clk_i);
        host.strobe(24);
      end
    join
    chk("strobe in frame", 4'h1, 4'(n_go - g0));
    // ****************************************************************
    // Repeat mode
    // ****************************************************************
    setc(2'h1, 1'b0, 1'b0, 1'b1, 4'(t));
    g0 = n_eoc;
    p0 = n_push;
    repeat (t) frame(16, 1'b0);
    chk("fifo level", 4'(t), lvl);
    chk("result_push count", 4'(t), 4'(n_push - p0));
    chk("int_n at threshold", 4'h0, {3'h0, int_n});
    chk("no eoc in repeat", 4'(g0), 4'(n_eoc));
    k = n_clr;
    frame(16, 1'b0);
    chk("fifo clear", 4'(k + 1), 4'(n_clr));
    chk("level after clear", 4'h1, lvl);
    repeat (t - 1) frame(16, 1'b0);
    chk("int_n refilled", 4'h0, {3'h0, int_n});
    frame(4, 1'b1);
    chk("no clear on read", 4'(k + 1), 4'(n_clr));
    chk("level after read", 4'(t - 1), lvl);
    g0 = n_go;
    frame(16, 1'b0);
    chk("same channel resumes", 4'(t), lvl);
    setc(2'h1, 1'b1, 1'b0, 1'b0, 4'hf);
    host.strobe(24);
    settle();
    chk("extended repeat push", 4'(t + 1), lvl);
    // ****************************************************************
    // Sweep codes start nothing here
    // ****************************************************************
    for (int m = 2; m < 4; m++)
    begin
      setc(2'(m), 1'b0, 1'b0, 1'b0, 4'hf);
      g0 = n_go;
      frame(16, 1'b0);
      chk("sweep code conv_go", 4'h0, 4'(n_go - g0));
    end
    end_of_test();
  end
endmodule

`default_nettype wire
